// file: pbs_sequencer.sv
/*
 pbs_sequencer: push-button on/off power sequencer with processor
 shutdown handshake. Assumes the button and acknowledge pins are
 asynchronous and pulled up outside; one 100 MHz clock.
*/
// Behaviour
// - After reset, enable is released and power-down request inactive.
// - Enable asserts only after button held low 128 ms while off.
// - Any high on the button restarts a running turn-on or turn-off debounce.
// - After enable, ignore acknowledge and button for 512 ms.
// - Acknowledge still low when blanking ends releases the enable.
// - After blanking, button release debounced 32 ms before off monitoring.
// - Turn-off press needs 32 ms continuous low plus extra count.
// - With zero extra count turn-off debounce is 32 to 33 ms.
// - A valid turn-off press drives the power-down request low.
// - Failsafe of 128 ms plus extension releases enable on expiry.
// - Acknowledge low during failsafe releases enable at once.
// - Acknowledge low any time after blanking releases the enable.
// - After button turn-off, release debounced 32 ms before idle takes a new press.
// - A parameter selects active-high or active-low enable.
// - Power-down request is open drain: pulls low or floats.
// - After enable release, ignore the button for 256 ms.
// - Acknowledge low shorter than 30 us is filtered out, except at blanking end.
`timescale 1ns/1ns
`default_nettype none
module pbs_sequencer #(
	parameter bit ENABLE_ACTIVE_HIGH = 1'b1, // enable polarity
	parameter int unsigned TICK_CYCLES = pbs_pkg::TICK_CYCLES,
	parameter int unsigned off_debounce_extend = 0, // extra 1 ms ticks
	parameter int unsigned ack_timeout_extend = 0 // extra 1 ms ticks
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic push_button_n, // button pin, low = pressed
	input wire logic shutdown_ack_n, // processor done, low active
	output logic power_enable, // enable pin level, polarity by parameter
	output logic power_down_request_n_out, // always low when driven
	output logic power_down_request_n_oe, // high while pulling low
	output logic powerOn // internal enable state
);
	localparam int unsigned TW = pbs_pkg::TIMER_W;
	// one tick more than the interval: the tick phase runs free, so the
	// first tick may come at once and N+1 ticks still give N full ones
	localparam logic [TW-1:0] ON_LEN = TW'(pbs_pkg::ON_DEBOUNCE_MS + 1);
	localparam logic [TW-1:0] BLANK_LEN = TW'(pbs_pkg::BLANK_MS + 1);
	localparam logic [TW-1:0] OFF_LEN =
		TW'(pbs_pkg::OFF_DEBOUNCE_MS + off_debounce_extend + 1);
	localparam logic [TW-1:0] FAIL_LEN =
		TW'(pbs_pkg::FAILSAFE_MS + ack_timeout_extend + 1);
	localparam logic [TW-1:0] LOCK_LEN = TW'(pbs_pkg::LOCKOUT_MS + 1);
	localparam logic [TW-1:0] REL_LEN = TW'(pbs_pkg::RELEASE_MS + 1);

	pbs_pkg::pbs_state_t state;
	logic button;
	logic ackRaw;
	logic ackLow;
	logic [$clog2(TICK_CYCLES+1)-1:0] divCount;
	logic tick;
	logic [TW-1:0] timer;
	logic requestActive;
	logic releasePending;
	logic [TW-1:0] relTimer;

	////////////////////////////////////////////////////////////////
	// input conditioning
	pbs_sync_filter #(.LOW_CYCLES(1)) uButton (
		.clk(clk),
		.rst(rst),
		.asyncIn(push_button_n),
		.syncOut(button),
		.lowQual()
	);

	// acknowledge must stay low the filter time before it counts
	pbs_sync_filter #(.LOW_CYCLES(pbs_pkg::ACK_FILTER_CYCLES)) uAck (
		.clk(clk),
		.rst(rst),
		.asyncIn(shutdown_ack_n),
		.syncOut(ackRaw),
		.lowQual(ackLow)
	);

	////////////////////////////////////////////////////////////////
	// 1 ms tick divider
	always_ff @(posedge clk)
	begin
		if (rst || tick)
			divCount <= '0;
		else
			divCount <= divCount + 1'b1;
	end
	assign tick = divCount == ($bits(divCount))'(TICK_CYCLES - 1);

	////////////////////////////////////////////////////////////////
	// main sequencer; timer counts ticks and is cleared on entry
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state <= pbs_pkg::PBS_IDLE;
			timer <= '0;
		end
		else
		begin
			unique case (state)
			pbs_pkg::PBS_IDLE:
			begin
				timer <= '0;
				// a button still held from turn-off is no new press
				if (!button && !releasePending)
					state <= pbs_pkg::PBS_ON_DEB;
			end
			pbs_pkg::PBS_ON_DEB:
			begin
				if (button)
					state <= pbs_pkg::PBS_IDLE;
				else if (timer == ON_LEN)
				begin
					state <= pbs_pkg::PBS_BLANK;
					timer <= '0;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			// inputs ignored while converter and processor start
			pbs_pkg::PBS_BLANK:
			begin
				if (timer == BLANK_LEN)
				begin
					timer <= '0;
					if (!ackRaw)
						state <= pbs_pkg::PBS_LOCKOUT;
					else
						state <= pbs_pkg::PBS_REL_DEB;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			// button must read released for 32 ms before arming
			pbs_pkg::PBS_REL_DEB:
			begin
				if (ackLow)
				begin
					state <= pbs_pkg::PBS_LOCKOUT;
					timer <= '0;
				end
				else if (!button)
					timer <= '0;
				else if (timer == REL_LEN)
				begin
					state <= pbs_pkg::PBS_RUN;
					timer <= '0;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			pbs_pkg::PBS_RUN:
			begin
				timer <= '0;
				if (ackLow)
					state <= pbs_pkg::PBS_LOCKOUT;
				else if (!button)
					state <= pbs_pkg::PBS_OFF_DEB;
			end
			pbs_pkg::PBS_OFF_DEB:
			begin
				if (ackLow)
				begin
					state <= pbs_pkg::PBS_LOCKOUT;
					timer <= '0;
				end
				else if (button)
					state <= pbs_pkg::PBS_RUN;
				else if (timer == OFF_LEN)
				begin
					state <= pbs_pkg::PBS_FAILSAFE;
					timer <= '0;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			// processor housekeeping window, bounded by failsafe
			pbs_pkg::PBS_FAILSAFE:
			begin
				if (ackLow || timer == FAIL_LEN)
				begin
					state <= pbs_pkg::PBS_LOCKOUT;
					timer <= '0;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			// button ignored so the rail can decay fully
			pbs_pkg::PBS_LOCKOUT:
			begin
				if (timer == LOCK_LEN)
				begin
					state <= pbs_pkg::PBS_IDLE;
					timer <= '0;
				end
				else if (tick)
					timer <= timer + 1'b1;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// release debounce after a button turn-off; runs beside lockout
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			releasePending <= 1'b0;
			relTimer <= '0;
		end
		else if (state == pbs_pkg::PBS_OFF_DEB && timer == OFF_LEN &&
			!ackLow && !button)
		begin
			releasePending <= 1'b1;
			relTimer <= '0;
		end
		else if (releasePending)
		begin
			if (!button)
				relTimer <= '0;
			else if (relTimer == REL_LEN)
				releasePending <= 1'b0;
			else if (tick)
				relTimer <= relTimer + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// outputs from flops; request held only through failsafe wait
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			powerOn <= 1'b0;
			requestActive <= 1'b0;
		end
		else
		begin
			powerOn <= state == pbs_pkg::PBS_BLANK ||
				state == pbs_pkg::PBS_REL_DEB ||
				state == pbs_pkg::PBS_RUN ||
				state == pbs_pkg::PBS_OFF_DEB ||
				state == pbs_pkg::PBS_FAILSAFE;
			requestActive <= state == pbs_pkg::PBS_FAILSAFE;
		end
	end

	// enable polarity is a build option; the request only ever pulls low
	assign power_enable = ENABLE_ACTIVE_HIGH ? powerOn : !powerOn;
	assign power_down_request_n_out = 1'b0;
	assign power_down_request_n_oe = requestActive;
endmodule
`default_nettype wire

// file: pbs_pkg.sv
/*
 pbs_pkg: timing constants and state encoding for the push-button
 power sequencer. Assumes a 100 MHz system clock.
*/
package pbs_pkg;
	// clock rate in kHz, timer tick period
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = CLK_KHZ * TICK_US / 1000;
	// interval lengths in ms, counted in 1 ms ticks
	localparam int unsigned ON_DEBOUNCE_MS = 128;
	localparam int unsigned BLANK_MS = 512;
	localparam int unsigned OFF_DEBOUNCE_MS = 32;
	localparam int unsigned FAILSAFE_MS = 128;
	localparam int unsigned LOCKOUT_MS = 256;
	localparam int unsigned RELEASE_MS = 32;
	// acknowledge glitch filter, least time rounds up
	localparam int unsigned ACK_FILTER_NS = 30000;
	localparam int unsigned ACK_FILTER_CYCLES = (ACK_FILTER_NS + 9) / 10;
	localparam int unsigned TIMER_W = 16;

	// sequencer states, gray along the normal path
	typedef enum logic [2:0] {
		PBS_IDLE = 3'b000,
		PBS_ON_DEB = 3'b001,
		PBS_BLANK = 3'b011,
		PBS_REL_DEB = 3'b010,
		PBS_RUN = 3'b110,
		PBS_OFF_DEB = 3'b111,
		PBS_FAILSAFE = 3'b101,
		PBS_LOCKOUT = 3'b100
	} pbs_state_t;
endpackage

// file: pbs_sync_filter.sv
/*
 pbs_sync_filter: two-flop synchroniser followed by an optional
 low-level qualifier. Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module pbs_sync_filter #(
	parameter int unsigned LOW_CYCLES = 1
) (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic asyncIn, // raw pin level
	output logic syncOut, // synchronised level
	output logic lowQual // low held for LOW_CYCLES
);
	logic meta;
	logic [$clog2(LOW_CYCLES+1):0] lowCount;

	// resets high: idle level of both active-low inputs
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			meta <= 1'b1;
			syncOut <= 1'b1;
		end
		else
		begin
			meta <= asyncIn;
			syncOut <= meta;
		end
	end

	// short low pulses never reach the qualifier output
	always_ff @(posedge clk)
	begin
		if (rst || syncOut)
		begin
			lowCount <= '0;
			lowQual <= 1'b0;
		end
		else if (lowCount < ($bits(lowCount))'(LOW_CYCLES))
		begin
			lowCount <= lowCount + 1'b1;
			lowQual <= (lowCount + 1'b1) >= ($bits(lowCount))'(LOW_CYCLES);
		end
	end
endmodule
`default_nettype wire

// file: pbs_cpu_model.sv
/*
 pbs_cpu_model: processor side of the shutdown handshake.
 Assumes supplyOn follows the enable pin and reqN is pulled up.
*/
`timescale 1ns/1ns
`default_nettype none
module pbs_cpu_model #(
	parameter int BOOT = 2000 // boot cycles, well inside blanking
) (
	input wire logic clk, // clock
	input wire logic [1:0] mode, // 0 answers, 1 never boots, 2 ignores
	input wire logic supplyOn, // system supply
	input wire logic reqN, // request wire
	output logic ackN // acknowledge
);
	int upCnt = 0;
	initial ackN = 1'b0;
	// low while unpowered, high after boot, low once housekeeping is done;
	// mode 0 answers at once, as a request wired to the acknowledge would
	always @(posedge clk)
	begin
		upCnt <= supplyOn ? upCnt + 1 : 0;
		ackN <= supplyOn && mode != 2'h1 && upCnt >= BOOT
			&& !(mode == 2'h0 && !reqN);
	end
endmodule
`default_nettype wire

// file: pbs_sequencer_sva.sv
/*
 pbs_sequencer_chk: timing checks on the sequencer ports.
 Assumes one clock and a synchronous reset held 3 cycles or more.
*/
`timescale 1ns/1ns
`default_nettype none
module pbs_sequencer_chk #(
	parameter bit ENABLE_ACTIVE_HIGH = 1'b1,
	parameter int unsigned TICK_CYCLES = 10,
	parameter int unsigned off_debounce_extend = 0,
	parameter int unsigned ack_timeout_extend = 0
) (
	input wire logic clk, // clock
	input wire logic rst, // reset
	input wire logic push_button_n, // button
	input wire logic shutdown_ack_n, // ack
	input wire logic power_enable, // enable pin
	input wire logic power_down_request_n_out, // request data
	input wire logic power_down_request_n_oe, // request enable
	input wire logic powerOn // on state
);
	localparam int T = TICK_CYCLES;
	localparam int AF = pbs_pkg::ACK_FILTER_CYCLES;
	localparam int OFFX = off_debounce_extend * T;
	localparam int FSX = ack_timeout_extend * T;
	int lowCnt, ackLow, onCnt, offCnt, reqCnt, onAtAck;
	////////////////////////////////////////////////////////////////
	// run lengths; offCnt starts large so the first turn-on passes
	always_ff @(posedge clk)
	begin
		lowCnt <= push_button_n ? 0 : lowCnt + 1;
		ackLow <= shutdown_ack_n ? 0 : ackLow + 1;
		onCnt <= powerOn ? onCnt + 1 : 0;
		offCnt <= rst ? 1000000 : (powerOn ? 0 : offCnt + 1);
		reqCnt <= power_down_request_n_oe ? reqCnt + 1 : 0;
		onAtAck <= shutdown_ack_n ? 0 : (ackLow == 0 ? onCnt : onAtAck);
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_on; $rose(powerOn); endsequence
	sequence s_off; $fell(powerOn); endsequence
	sequence s_req; $rose(power_down_request_n_oe); endsequence
	property p_rst;
		disable iff (1'b0) rst |=> !powerOn && !power_down_request_n_oe;
	endproperty
	property p_onDeb; s_on |-> lowCnt >= 128 * T; endproperty
	// lockout and then a full turn-on debounce lie between off and on
	property p_lock; s_on |-> offCnt >= 384 * T; endproperty
	property p_blank; s_off |-> onCnt >= 511 * T; endproperty
	property p_offDeb;
		s_req |-> lowCnt >= 32 * T + OFFX && lowCnt <= 33 * T + OFFX + 8;
	endproperty
	property p_fail;
		$fell(power_down_request_n_oe) |-> s_off and
			(reqCnt <= 129 * T + FSX + 8);
	endproperty
	property p_filt;
		s_off ##0 !$past(power_down_request_n_oe) |-> ackLow >= AF;
	endproperty
	property p_ack;
		ackLow == AF + 8 && onAtAck > 513 * T |-> !powerOn;
	endproperty
	property p_pol;
		power_enable == (ENABLE_ACTIVE_HIGH ? powerOn : !powerOn);
	endproperty
	// request never driven high, and only pulled while power is on
	property p_od;
		power_down_request_n_out == 1'b0 &&
			(!power_down_request_n_oe || powerOn);
	endproperty
	a_rst: assert property (p_rst) else $error("bad reset state");
	a_onDeb: assert property (p_onDeb) else $error("on too soon");
	a_lock: assert property (p_lock) else $error("lockout short");
	a_blank: assert property (p_blank) else $error("blank short");
	a_offDeb: assert property (p_offDeb) else $error("off debounce");
	a_fail: assert property (p_fail) else $error("failsafe");
	a_filt: assert property (p_filt) else $error("ack glitch");
	a_ack: assert property (p_ack) else $error("ack ignored");
	a_pol: assert property (p_pol) else $error("polarity");
	a_od: assert property (p_od) else $error("drives high");
endmodule
bind pbs_sequencer pbs_sequencer_chk #(
	.ENABLE_ACTIVE_HIGH(ENABLE_ACTIVE_HIGH), .TICK_CYCLES(TICK_CYCLES),
	.off_debounce_extend(off_debounce_extend),
	.ack_timeout_extend(ack_timeout_extend)
) u_chk (.clk, .rst, .push_button_n, .shutdown_ack_n, .power_enable,
	.power_down_request_n_out, .power_down_request_n_oe, .powerOn);
`default_nettype wire

// file: pbs_sequencer_tb.sv
/*
 pbs_sequencer_tb: power cycles against the processor model.
 Assumes a 25-cycle tick and an active-low enable build.
*/
`timescale 1ns/1ns
`default_nettype none
module pbs_sequencer_tb;
	localparam int T = 25; // shortened tick keeps the run short
	typedef struct packed {logic [1:0] mode; logic expOn;} pbs_row_t;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic btnN = 1'b1;
	logic [1:0] cpuMode = 2'h0;
	logic ackN, powerEn, reqOut, reqOe, powerOn;
	int mismatches = 0;
	int tests_run = 0;
	pbs_row_t rows [3] = '{'{2'h0, 1'b1}, '{2'h2, 1'b1}, '{2'h1, 1'b0}};
	// pulled-up open-drain request wire
	wire logic reqN = reqOe ? reqOut : 1'b1;
	always #5 clk = ~clk;
	pbs_sequencer #(.ENABLE_ACTIVE_HIGH(1'b0), .TICK_CYCLES(T)) u_dut (
		.clk(clk), .rst(rst), .push_button_n(btnN), .shutdown_ack_n(ackN),
		.power_enable(powerEn), .power_down_request_n_out(reqOut),
		.power_down_request_n_oe(reqOe), .powerOn(powerOn));
	pbs_cpu_model u_cpu (.clk(clk), .mode(cpuMode), .supplyOn(!powerEn),
		.reqN(reqN), .ackN(ackN));
	////////////////////////////////////////////////////////////////
	// sample just after the edge, then realign to the next edge
	task check(input logic [31:0] seen, input logic [31:0] exp);
		#1 tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
		@(posedge clk);
	endtask
	task ticks(input int n);
		repeat (n * T) @(posedge clk);
	endtask
	task press(input int n);
		btnN <= 1'b0;
		ticks(n);
		btnN <= 1'b1;
	endtask
	task close_out;
		$display("tests %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog sized a little above the expected run
	initial
	begin
		repeat (105000) @(posedge clk);
		mismatches++;
		close_out;
	end
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[k])
		begin
			cpuMode <= rows[k].mode;
			press(135);
			check(powerOn, 1);
			ticks(545);
			check(powerOn, rows[k].expOn);
			if (rows[k].expOn)
			begin
				// off press held on through lockout: no fresh turn-on
				btnN <= 1'b0;
				ticks(40);
				check(reqOe, 1);
				for (int i = 0; i < 6000 && powerOn === 1'b1; i++)
					@(posedge clk);
				check({powerOn, reqOe}, 0);
				ticks(390);
				check(powerOn, 0);
				btnN <= 1'b1;
				ticks(40);
			end
			else
			begin
				press(135);
				check(powerOn, 0);
				ticks(135);
			end
			$display("row %0d done", k);
		end
		// reset in mid-run, then a bouncing press
		press(135);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		check({powerOn, reqOe, powerEn, reqOut}, 4'h2);
		press(100);
		ticks(1);
		press(100);
		ticks(40);
		check(powerOn, 0);
		$display("reset and bounce done");
		close_out;
	end
endmodule
`default_nettype wire
